// file: hw/tmr_ff_consts.svh
// Summary of operation
// - Capture into capture register 1 toggles the output flip-flop when enabled.
// - Capture into capture register 0 toggles the output flip-flop when enabled.
// - Counter match with compare register 1 toggles the flip-flop when enabled.
// - Counter match with compare register 0 toggles the flip-flop when enabled.
// - Command write: 00 inverts, 01 sets, 10 clears the output flip-flop.
// - Command 11 does nothing; command field and bits 7:6 read as 11.
// - Status bit 2 reports an up-counter overflow interrupt.
// - Status bit 1 reports a compare register 1 match interrupt.
// - Status bit 0 reports a compare register 0 match interrupt.
// - Each interrupt event sets its own status flag.
// - Reading status returns the flags, then clears them all except a flag whose event comes in the read cycle.
// - Mask bit 2 blocks the overflow interrupt request when set.
// - Mask bit 1 blocks the compare 1 match request when set.
// - Mask bit 0 blocks the compare 0 match request when set.
// - Run bit clear stops and zeroes the counter; set starts counting.
`ifndef TMR_FF_CONSTS_SVH
`define TMR_FF_CONSTS_SVH
`define ADR_FFCTRL 4'h0
`define ADR_STATUS 4'h1
`define ADR_MASK 4'h2
`define ADR_RUN 4'h3
`define ADR_CMP0 4'h4
`define ADR_CMP1 4'h5
`define ADR_CAP0 4'h6
`define ADR_CAP1 4'h7
`define ADR_ICLR 4'h8
`define ADR_IEN 4'h9
`define BIT_C1T 5
`define BIT_C0T 4
`define BIT_E1T 3
`define BIT_E0T 2
`define BIT_OVF 2
`define BIT_M1 1
`define BIT_M0 0
`define FF_RSVD_HI 2'h3
`define FF_CMD_RD 2'h3
`define RUN_BIT 0
`endif

// file: hw/tmr_ff_pkg.sv
package tmr_ff_pkg;
  typedef enum logic [1:0] {
    FF_INVERT = 2'b00,
    FF_SET = 2'b01,
    FF_CLEAR = 2'b10,
    FF_KEEP = 2'b11
  } ff_cmd_e;
endpackage : tmr_ff_pkg

// file: hw/tmr_counter.sv
`timescale 1ns/1ps
`include "tmr_ff_consts.svh"
module tmr_counter #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [W-1:0] cmp0_i,
  input wire logic [W-1:0] cmp1_i,
  output logic [W-1:0] count_o,
  output logic match0_o,
  output logic match1_o,
  output logic ovf_o
);
  initial begin
    if (W < 2 || W > 32) $error("tmr_counter width out of range");
  end
  logic [W-1:0] cnt_q, cnt_d;
  always_comb begin
    if (!run_i) cnt_d = '0;
    else cnt_d = cnt_q + W'(1);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
  assign count_o = cnt_q;
  assign match0_o = run_i && (cnt_q == cmp0_i);
  assign match1_o = run_i && (cnt_q == cmp1_i);
  assign ovf_o = run_i && (&cnt_q);
  chk_stop_clears_count: assert property (@(posedge clk_i) disable iff (rst_i)
    !run_i |=> cnt_q == '0) else $error("counter not cleared while stopped");
endmodule : tmr_counter

// file: hw/tmr_capture.sv
`timescale 1ns/1ps
module tmr_capture #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic trig_i,
  input wire logic [W-1:0] count_i,
  output logic [W-1:0] value_o,
  output logic event_o
);
  initial begin
    if (W < 2) $error("tmr_capture width out of range");
  end
  logic s1_q, s2_q, s3_q;
  logic [W-1:0] val_q, val_d;
  logic ev;
  // Pin crosses into clk domain first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= trig_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign ev = run_i && s2_q && !s3_q;
  always_comb begin
    val_d = ev ? count_i : val_q;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) val_q <= '0;
    else val_q <= val_d;
  end
  assign value_o = val_q;
  assign event_o = ev;
endmodule : tmr_capture

// file: hw/tmr_ff_irq.sv
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tmr_ff_consts.svh"
module tmr_ff_irq #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cap0_pin_i,
  input wire logic cap1_pin_i,
  output logic output_flipflop_o,
  output logic irq_o
);
  initial begin
    if (W < 2 || W > 32) $error("tmr_ff_irq width out of range");
  end

  function automatic logic hit(input logic [5:0] a, input logic [3:0] idx);
    hit = (a[5:2] == idx);
  endfunction : hit

  logic req;
  logic wr;
  logic rd;
  logic [W-1:0] count;
  logic m0, m1, ovf, c0, c1;
  logic [W-1:0] cap0_val, cap1_val;

  // Control and status state
  logic run_q, run_d;
  logic [3:0] ten_q, ten_d;
  logic [2:0] flag_q, flag_d;
  logic [2:0] mask_q, mask_d;
  logic [2:0] ien_q, ien_d;
  logic [W-1:0] cmp0_q, cmp0_d, cmp1_q, cmp1_d;
  logic ff_q, ff_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic irq_q, irq_d;
  logic [2:0] ev;
  logic [2:0] act_flags;

  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;

  tmr_counter #(.W(W)) u_cnt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_q),
    .cmp0_i(cmp0_q),
    .cmp1_i(cmp1_q),
    .count_o(count),
    .match0_o(m0),
    .match1_o(m1),
    .ovf_o(ovf)
  );

  tmr_capture #(.W(W)) u_cap0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_q),
    .trig_i(cap0_pin_i),
    .count_i(count),
    .value_o(cap0_val),
    .event_o(c0)
  );

  tmr_capture #(.W(W)) u_cap1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(run_q),
    .trig_i(cap1_pin_i),
    .count_i(count),
    .value_o(cap1_val),
    .event_o(c1)
  );

  assign ev = {ovf, m1, m0};

  // Register writes
  always_comb begin
    run_d = run_q;
    ten_d = ten_q;
    mask_d = mask_q;
    ien_d = ien_q;
    cmp0_d = cmp0_q;
    cmp1_d = cmp1_q;
    if (wr) begin
      if (hit(adr_i, `ADR_RUN)) run_d = dat_i[`RUN_BIT];
      if (hit(adr_i, `ADR_FFCTRL)) ten_d = dat_i[`BIT_C1T:`BIT_E0T];
      if (hit(adr_i, `ADR_MASK)) mask_d = dat_i[2:0];
      if (hit(adr_i, `ADR_IEN)) ien_d = dat_i[2:0];
      if (hit(adr_i, `ADR_CMP0)) cmp0_d = dat_i[W-1:0];
      if (hit(adr_i, `ADR_CMP1)) cmp1_d = dat_i[W-1:0];
    end
  end

  // Flip-flop: event toggles combine as parity; software command last
  always_comb begin
    logic tog;
    tog = 1'b0;
    tog = tog ^ (ten_q[`BIT_C1T-2] & c1);
    tog = tog ^ (ten_q[`BIT_C0T-2] & c0);
    tog = tog ^ (ten_q[`BIT_E1T-2] & m1);
    tog = tog ^ (ten_q[`BIT_E0T-2] & m0);
    ff_d = ff_q ^ tog;
    // Writes while running are the caller's fault; handled anyway
    if (wr && hit(adr_i, `ADR_FFCTRL)) begin
      case (tmr_ff_pkg::ff_cmd_e'(dat_i[1:0]))
        tmr_ff_pkg::FF_INVERT: ff_d = ~ff_q;
        tmr_ff_pkg::FF_SET: ff_d = 1'b1;
        tmr_ff_pkg::FF_CLEAR: ff_d = 1'b0;
        tmr_ff_pkg::FF_KEEP: ff_d = ff_d;
        default: ff_d = ff_d;
      endcase
    end
  end

  // Flags: events win over read clear and write clear
  always_comb begin
    flag_d = flag_q;
    if (rd && hit(adr_i, `ADR_STATUS)) flag_d = 3'h0;
    if (wr && hit(adr_i, `ADR_ICLR)) flag_d = flag_d & ~dat_i[2:0];
    flag_d = flag_d | ev;
  end

  // Request to controller: unmasked and enabled flags
  assign act_flags = flag_q & ~mask_q & ien_q;
  always_comb begin
    irq_d = |(flag_d & ~mask_d & ien_d);
  end

  // Read mux and ack
  always_comb begin
    rdat_d = 32'h0;
    ack_d = req;
    if (rd) begin
      case (adr_i[5:2])
        `ADR_FFCTRL: rdat_d = {24'h0, `FF_RSVD_HI, ten_q, `FF_CMD_RD};
        `ADR_STATUS: rdat_d = {29'h0, flag_q};
        `ADR_MASK: rdat_d = {29'h0, mask_q};
        `ADR_RUN: rdat_d = {31'h0, run_q};
        `ADR_CMP0: rdat_d = 32'(cmp0_q);
        `ADR_CMP1: rdat_d = 32'(cmp1_q);
        `ADR_CAP0: rdat_d = 32'(cap0_val);
        `ADR_CAP1: rdat_d = 32'(cap1_val);
        `ADR_IEN: rdat_d = {29'h0, ien_q};
        default: rdat_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      ten_q <= 4'h0;
      flag_q <= 3'h0;
      mask_q <= 3'h0;
      ien_q <= 3'h7;
      cmp0_q <= '0;
      cmp1_q <= '0;
      ff_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      run_q <= run_d;
      ten_q <= ten_d;
      flag_q <= flag_d;
      mask_q <= mask_d;
      ien_q <= ien_d;
      cmp0_q <= cmp0_d;
      cmp1_q <= cmp1_d;
      ff_q <= ff_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_q <= irq_d;
    end
  end

  assign dat_o = rdat_q;
  assign ack_o = ack_q;
  assign output_flipflop_o = ff_q;
  assign irq_o = irq_q;

  // Flip-flop toggles and commands
  chk_match0_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (m0 && ten_q[0] && !m1 && !c0 && !c1 && !wr)
    |=> ff_q != $past(ff_q))
    else $error("match 0 did not toggle");
  chk_match1_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (m1 && ten_q[1] && !m0 && !c0 && !c1 && !wr)
    |=> ff_q != $past(ff_q))
    else $error("match 1 did not toggle");
  chk_cap0_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (c0 && ten_q[2] && !m0 && !m1 && !c1 && !wr)
    |=> ff_q != $past(ff_q))
    else $error("capture 0 did not toggle");
  chk_cap1_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    (c1 && ten_q[3] && !m0 && !m1 && !c0 && !wr)
    |=> ff_q != $past(ff_q))
    else $error("capture 1 did not toggle");
  chk_match0_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (m0 && !ten_q[0] && !m1 && !c0 && !c1 && !wr)
    |=> ff_q == $past(ff_q))
    else $error("disabled match 0 toggled");
  chk_match1_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (m1 && !ten_q[1] && !m0 && !c0 && !c1 && !wr)
    |=> ff_q == $past(ff_q))
    else $error("disabled match 1 toggled");
  chk_cap0_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (c0 && !ten_q[2] && !m0 && !m1 && !c1 && !wr)
    |=> ff_q == $past(ff_q))
    else $error("disabled capture 0 toggled");
  chk_cap1_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (c1 && !ten_q[3] && !m0 && !m1 && !c0 && !wr)
    |=> ff_q == $past(ff_q))
    else $error("disabled capture 1 toggled");
  chk_no_event_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (!wr && !(m0 && ten_q[0]) && !(m1 && ten_q[1])
    && !(c0 && ten_q[2]) && !(c1 && ten_q[3])) |=> ff_q == $past(ff_q))
    else $error("flip-flop changed with no cause");
  chk_cmd_set_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_FFCTRL) && dat_i[1:0] != 2'h3 && dat_i[1:0] != 2'h0)
    |=> ff_q == !$past(dat_i[1]))
    else $error("flip-flop command ignored");
  chk_cmd_invert: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_FFCTRL) && dat_i[1:0] == 2'h0)
    |=> ff_q != $past(ff_q))
    else $error("invert command ignored");
  chk_cmd_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_FFCTRL) && dat_i[1:0] == 2'h3 && !m0 && !m1 && !c0 && !c1)
    |=> ff_q == $past(ff_q))
    else $error("command 11 changed the flip-flop");
  chk_ffctrl_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_FFCTRL))
    |=> ack_q && dat_o[7:6] == 2'h3 && dat_o[1:0] == 2'h3)
    else $error("control readback wrong");
  chk_ffctrl_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_FFCTRL))
    |=> dat_o[31:8] == 24'h0)
    else $error("control upper bits not zero");
  chk_enables_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_FFCTRL))
    |=> dat_o[`BIT_C1T:`BIT_E0T] == $past(ten_q))
    else $error("toggle enables read back wrong");
  chk_enables_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_FFCTRL))
    |=> ten_q == $past(dat_i[`BIT_C1T:`BIT_E0T]))
    else $error("toggle enables not stored");

  // Event flags and status reads
  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf
    |=> flag_q[`BIT_OVF])
    else $error("overflow flag not set");
  chk_flag_m1: assert property (@(posedge clk_i) disable iff (rst_i)
    m1
    |=> flag_q[`BIT_M1])
    else $error("match 1 flag not set");
  chk_flag_m0: assert property (@(posedge clk_i) disable iff (rst_i)
    m0
    |=> flag_q[`BIT_M0])
    else $error("match 0 flag not set");
  chk_ovf_rise_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_q[`BIT_OVF])
    |-> $past(ovf))
    else $error("overflow flag set without overflow");
  chk_m1_rise_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_q[`BIT_M1])
    |-> $past(m1))
    else $error("match 1 flag set without match");
  chk_m0_rise_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(flag_q[`BIT_M0])
    |-> $past(m0))
    else $error("match 0 flag set without match");
  chk_flag_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev == 3'h0 && !(rd && hit(adr_i, `ADR_STATUS)) && !(wr && hit(adr_i, `ADR_ICLR)))
    |=> flag_q == $past(flag_q))
    else $error("flag changed with no cause");
  chk_status_read_data: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_STATUS))
    |=> dat_o == {29'h0, $past(flag_q)})
    else $error("status read data wrong");
  chk_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_STATUS) && ev == 3'h0)
    |=> flag_q == 3'h0 && !irq_q)
    else $error("status read did not clear");
  chk_read_keeps_event: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_STATUS))
    |=> flag_q == $past(ev))
    else $error("event lost at status read");
  chk_write_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_ICLR))
    |=> (flag_q & $past(dat_i[2:0]) & ~$past(ev)) == 3'h0)
    else $error("write clear left a flag set");
  chk_flag_ignores_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    (m0 && mask_q[`BIT_M0])
    |=> flag_q[`BIT_M0])
    else $error("masked event did not set its flag");

  // Interrupt request
  chk_mask_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_q
    |-> |act_flags)
    else $error("masked interrupt reached output");
  chk_unmasked_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (|act_flags)
    |-> irq_q)
    else $error("unmasked flag gave no request");
  chk_all_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    ((flag_q & ~mask_q) == 3'h0)
    |-> !irq_q)
    else $error("request with every flag masked");
  chk_ovf_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q[`BIT_OVF] && !mask_q[`BIT_OVF] && ien_q[`BIT_OVF])
    |-> irq_q)
    else $error("overflow gave no request");
  chk_m1_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q[`BIT_M1] && !mask_q[`BIT_M1] && ien_q[`BIT_M1])
    |-> irq_q)
    else $error("match 1 gave no request");
  chk_m0_request: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_q[`BIT_M0] && !mask_q[`BIT_M0] && ien_q[`BIT_M0])
    |-> irq_q)
    else $error("match 0 gave no request");
  chk_enable_gates: assert property (@(posedge clk_i) disable iff (rst_i)
    (ien_q == 3'h0)
    |-> !irq_q)
    else $error("request with all sources disabled");
  chk_mask_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_MASK))
    |=> mask_q == $past(dat_i[2:0]))
    else $error("mask not stored");
  chk_mask_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && hit(adr_i, `ADR_MASK))
    |=> dat_o == {29'h0, $past(mask_q)})
    else $error("mask read back wrong");

  // Run control, bus and reset
  chk_run_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && hit(adr_i, `ADR_RUN))
    |=> run_q == $past(dat_i[`RUN_BIT]))
    else $error("run bit not stored");
  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q
    |=> !ack_q)
    else $error("acknowledge held past one cycle");
  chk_reset_state: assert property (@(posedge clk_i)
    rst_i
    |=> !ff_q && !irq_q && !ack_q && flag_q == 3'h0)
    else $error("state not cleared by reset");
endmodule : tmr_ff_irq

// file: sim/pin_side.sv
`timescale 1ns/1ps
module pin_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire0_i,
  input wire logic fire1_i,
  output logic cap0_pin_o,
  output logic cap1_pin_o
);
  logic [2:0] c0_q;
  logic [2:0] c1_q;
  // Pulse held 4 clocks so the two-stage sync surely sees it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c0_q <= 3'h0;
      c1_q <= 3'h0;
    end else begin
      c0_q <= fire0_i ? 3'h4 : (c0_q != 3'h0 ? c0_q - 3'h1 : 3'h0);
      c1_q <= fire1_i ? 3'h4 : (c1_q != 3'h0 ? c1_q - 3'h1 : 3'h0);
    end
  end
  assign cap0_pin_o = (c0_q != 3'h0);
  assign cap1_pin_o = (c1_q != 3'h0);
endmodule : pin_side

// file: sim/tmr_ff_irq_bench.sv
`timescale 1ns/1ps
`include "tmr_ff_consts.svh"
module tmr_ff_irq_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic f0 = 1'b0;
  logic f1 = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] r;
  logic ack_o;
  logic ff_o;
  logic irq_o;
  logic p0;
  logic p1;
  int n_errors = 0;
  int comparisons = 0;
  logic [1:0] cmds [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic exp_ff [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  initial forever #25 clk_i = ~clk_i;
  tmr_ff_irq #(.W(16)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .cap0_pin_i(p0), .cap1_pin_i(p1), .output_flipflop_o(ff_o), .irq_o(irq_o));
  pin_side side (.clk_i(clk_i), .rst_i(rst_i), .fire0_i(f0), .fire1_i(f1),
    .cap0_pin_o(p0), .cap1_pin_o(p1));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Master holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    dat <= d;
    sel <= 4'hF;
    // Only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  // Longest test is the full counter wrap, about 3.3 ms
  initial begin
    #4000000;
    n_errors++;
    close_out();
  end
  initial begin
    tick(4);
    rst_i <= 1'b0;
    wb(1'b0, `ADR_FFCTRL, 32'h0);
    chk(r, 32'hC3);
    wb(1'b0, `ADR_MASK, 32'h0);
    chk(r, 32'h0);
    wb(1'b0, 4'hF, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `ADR_FFCTRL, {30'h0, cmds[i]});
      tick(2);
      chk(ff_o, exp_ff[i]);
    end
    wb(1'b1, `ADR_CMP0, 32'h5);
    wb(1'b1, `ADR_CMP1, 32'h9);
    wb(1'b1, `ADR_MASK, 32'h6);
    wb(1'b1, `ADR_FFCTRL, 32'h7);
    wb(1'b1, `ADR_RUN, 32'h1);
    tick(30);
    wb(1'b1, `ADR_RUN, 32'h0);
    chk(ff_o, 1'b0);
    chk(irq_o, 1'b1);
    wb(1'b1, `ADR_IEN, 32'h0);
    tick(2);
    chk(irq_o, 1'b0);
    wb(1'b1, `ADR_IEN, 32'h7);
    tick(2);
    chk(irq_o, 1'b1);
    wb(1'b1, `ADR_ICLR, 32'h1);
    tick(2);
    chk(irq_o, 1'b0);
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(r, 32'h2);
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(r, 32'h0);
    wb(1'b1, `ADR_FFCTRL, 32'hB);
    wb(1'b1, `ADR_RUN, 32'h1);
    tick(30);
    wb(1'b1, `ADR_RUN, 32'h0);
    chk(ff_o, 1'b1);
    wb(1'b1, `ADR_FFCTRL, 32'h33);
    wb(1'b1, `ADR_RUN, 32'h1);
    tick(20);
    f0 <= 1'b1;
    tick(1);
    f0 <= 1'b0;
    tick(10);
    chk(ff_o, 1'b0);
    f1 <= 1'b1;
    tick(1);
    f1 <= 1'b0;
    tick(10);
    chk(ff_o, 1'b1);
    wb(1'b1, `ADR_RUN, 32'h0);
    // Count is k-1 after edge k of the run write; pin seen 2 clocks after it rises
    wb(1'b0, `ADR_CAP0, 32'h0);
    chk(r, 32'h19);
    wb(1'b0, `ADR_CAP1, 32'h0);
    chk(r, 32'h24);
    wb(1'b1, `ADR_ICLR, 32'h7);
    wb(1'b1, `ADR_FFCTRL, 32'h3);
    wb(1'b1, `ADR_MASK, 32'h3);
    wb(1'b1, `ADR_RUN, 32'h1);
    // Long enough to pass the top count and both compares again
    tick(65600);
    wb(1'b1, `ADR_RUN, 32'h0);
    chk(irq_o, 1'b1);
    chk(ff_o, 1'b1);
    wb(1'b1, `ADR_MASK, 32'h7);
    tick(2);
    chk(irq_o, 1'b0);
    wb(1'b0, `ADR_STATUS, 32'h0);
    chk(r, 32'h7);
    close_out();
  end
endmodule : tmr_ff_irq_bench
